/* design/key_scan_pkg.sv */
// constants and carrier types for the front-panel key scan and auto-repeat unit
// assumes a 25 MHz core clock and a 16-position multiplexed display
package key_scan_pkg;
	// ==========================================
	// clock and scan timing
	localparam int CLK_HZ = 25000000;
	localparam int SCAN_PERIOD_MS = 5;
	localparam int NUM_DIGITS = 16;
	// digit time is a longest time, so it rounds down
	localparam int DIGIT_CYCLES = SCAN_PERIOD_MS * (CLK_HZ / 1000) / NUM_DIGITS;
	localparam logic [3:0] SCAN_PULSE_SLOT = 4'h0;
	// ==========================================
	// processor ports
	localparam logic [15:0] DATA_PORT_ADDR = 16'hD000;
	localparam logic [15:0] CMD_PORT_ADDR = 16'hD001;
	localparam logic [3:0] CMD_SET_ADDR = 4'h8;
	localparam logic [7:0] CMD_CLEAR = 8'hC0;
	localparam int STAT_KEY_BIT = 0;
	localparam int STAT_REPEAT_BIT = 1;
	localparam int CODE_SCAN_LSB = 3;
	localparam logic [7:0] DISP_RESET = 8'h00;
	localparam logic [7:0] CODE_RESET = 8'h00;
	localparam logic [7:0] STEP_RETURN_MASK = 8'hF0;
	// ==========================================
	// repeat counter chain
	localparam logic [3:0] UPPER_SLOW = 4'h8;
	localparam logic [3:0] UPPER_FAST = 4'h2;
	localparam logic [3:0] TEN_RESET = 4'h0;
	localparam logic [3:0] TEN_LAST = 4'h9;
	// ==========================================
	// synchronised processor strobes and data
	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic cs_n;
		logic cd;
		logic [7:0] data;
	} bus_pins_t;
endpackage

/* design/repeat_counter.sv */
// cascaded divide-by-ten and upper counter with two phase flip-flops
// assumes tick is a one-cycle pulse per scan cycle and hold is already synchronous
`timescale 1ns/10ps
module repeat_counter #(
	parameter logic [3:0] UPPER_SLOW = key_scan_pkg::UPPER_SLOW,
	parameter logic [3:0] UPPER_FAST = key_scan_pkg::UPPER_FAST,
	parameter logic [3:0] TEN_LAST = key_scan_pkg::TEN_LAST
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic hold,
	input wire logic tick,
	output logic borrow
);
	logic [3:0] upper_r;
	logic [3:0] ten_r;
	logic ph1_r;
	logic ph2_r;
	logic ten_wrap;
	logic [3:0] reload;

	// ==========================================
	// counting
	assign ten_wrap = tick && (ten_r == TEN_LAST);
	assign borrow = hold && ten_wrap && (upper_r == 4'h1);
	// third borrow onward reloads the short count, ph2 drops at the second
	assign reload = ph2_r ? UPPER_SLOW : UPPER_FAST;

	always_ff @(posedge core_clk) begin
		if (reset || (ce && !hold)) begin
			upper_r <= UPPER_SLOW;
			ten_r <= key_scan_pkg::TEN_RESET;
			ph1_r <= 1'b1;
			ph2_r <= 1'b1;
		end else if (ce && tick) begin
			ten_r <= ten_wrap ? key_scan_pkg::TEN_RESET : 4'(ten_r + 4'h1);
			if (borrow) begin
				upper_r <= reload;
				if (ph1_r) begin
					ph1_r <= 1'b0;
				end else if (ph2_r) begin
					ph2_r <= 1'b0;
				end
			end else if (ten_wrap) begin
				upper_r <= 4'(upper_r - 4'h1);
			end
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_final_count;
		ce && hold && tick && ten_r == TEN_LAST && upper_r == 4'h1;
	endsequence

	a_idle_preset: assert property ((ce && !hold) |=> (upper_r == 4'h8 && ten_r == 4'h0 && ph1_r && ph2_r))
		else $error("repeat chain not preset while idle");
	a_tenfold_wrap: assert property ((ce && hold && tick && ten_r == 4'h9) |=> ten_r == 4'h0)
		else $error("tenfold divider did not wrap after ten");
	a_borrow_cause: assert property (borrow |-> (tick && upper_r == 4'h1 && ten_r == 4'h9))
		else $error("borrow without final count");
	a_reload_value: assert property (s_final_count |=> upper_r == ($past(ph2_r) ? 4'h8 : 4'h2))
		else $error("wrong reload after borrow");
	a_phase_order: assert property (s_final_count ##0 ph1_r |=> (!ph1_r && ph2_r))
		else $error("first borrow did not flip first phase only");
endmodule

/* design/key_scan_autorepeat.sv */
// front-panel scan unit: display refresh, key matrix scan, key codes and auto-repeat
// assumes processor strobes and key return lines are asynchronous pins
// What this block does
// - four binary scan select outputs step through the digit positions one at a time.
// - display memory is sent out as two 4-bit digit groups in step with the scan select.
// - the scan select is decoded into an active-low key scan pulse repeating every 5 ms.
// - a closed key stores its return line and the scan select state as its position code.
// - each key press, and each repeat step of a held step key, raises one interrupt request, read back with the code.
// - with no step key held the repeat chain sits preset at 8, 0, phases high, gate low.
// - the lower repeat stage divides scan pulses by ten.
// - a held step key counts 80 scan pulses, 400 ms, to a borrow.
// - each borrow makes a positive gate pulse that breaks the return path once.
// - the first two borrows flip the phases, then the upper stage reloads 2 for 100 ms steps.
// - repeat runs only for step keys and only while one stays held.
// - the key interrupt goes to the processor's maskable key interrupt input.
`timescale 1ns/10ps
module key_scan_autorepeat #(
	parameter int DIGIT_CYCLES = key_scan_pkg::DIGIT_CYCLES,
	parameter logic [7:0] STEP_RETURN_MASK = key_scan_pkg::STEP_RETURN_MASK
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic bus_rd_n,
	input wire logic bus_wr_n,
	input wire logic bus_cs_n,
	input wire logic bus_cd,
	input wire logic [7:0] bus_data_in,
	output logic [7:0] bus_data_out,
	output logic bus_data_oe,
	input wire logic [7:0] key_return_lines,
	output logic [3:0] scan_select_lines,
	output logic [3:0] digit_data_low_group,
	output logic [3:0] digit_data_high_group,
	output logic key_scan_n,
	output logic repeat_pulse_gate,
	output logic key_interrupt
);
	localparam logic [15:0] DIV_LAST = 16'(DIGIT_CYCLES - 1);

	// ==========================================
	// pin synchronisers
	key_scan_pkg::bus_pins_t bus_m_r;
	key_scan_pkg::bus_pins_t bus_s_r;
	key_scan_pkg::bus_pins_t bus_d_r;
	logic [7:0] ret_m_r;
	logic [7:0] ret_s_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			bus_m_r <= '1;
			bus_s_r <= '1;
			bus_d_r <= '1;
			ret_m_r <= 8'hFF;
			ret_s_r <= 8'hFF;
		end else if (ce) begin
			bus_m_r <= '{bus_rd_n, bus_wr_n, bus_cs_n, bus_cd, bus_data_in};
			bus_s_r <= bus_m_r;
			bus_d_r <= bus_s_r;
			ret_m_r <= key_return_lines;
			ret_s_r <= ret_m_r;
		end
	end

	// ==========================================
	// scan timing
	logic [15:0] div_r;
	logic [3:0] scan_r;
	logic [3:0] scan_nxt;
	logic digit_step;
	logic sample_evt;

	assign digit_step = (div_r == DIV_LAST);
	assign scan_nxt = 4'(scan_r + 4'h1);
	// sample at the end of the pulse slot so the return lines have settled
	assign sample_evt = digit_step && (scan_r == key_scan_pkg::SCAN_PULSE_SLOT);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_r <= 16'h0000;
			scan_r <= 4'h0;
		end else if (ce) begin
			div_r <= digit_step ? 16'h0000 : 16'(div_r + 16'h0001);
			if (digit_step) begin
				scan_r <= scan_nxt;
			end
		end
	end

	// ==========================================
	// processor port decode
	logic wr_done;
	logic rd_done;
	logic data_wr;
	logic cmd_wr;
	logic rd_active;
	logic code_read;
	logic [7:0] wr_byte;

	// address decode to FRONT_PANEL_DATA_PORT / FRONT_PANEL_COMMAND_PORT is outside: cs selects the pair, cd picks the port
	assign wr_done = bus_s_r.wr_n && !bus_d_r.wr_n && !bus_d_r.cs_n;
	assign rd_done = bus_s_r.rd_n && !bus_d_r.rd_n && !bus_d_r.cs_n;
	assign data_wr = wr_done && !bus_d_r.cd;
	assign cmd_wr = wr_done && bus_d_r.cd;
	assign code_read = rd_done && !bus_d_r.cd;
	assign rd_active = !bus_s_r.rd_n && !bus_s_r.cs_n;
	assign wr_byte = bus_d_r.data;

	// ==========================================
	// display memory
	logic [7:0] disp_mem_r [key_scan_pkg::NUM_DIGITS];
	logic [3:0] wr_ptr_r;
	logic clear_cmd;
	logic addr_cmd;
	logic [7:0] next_digit;

	assign clear_cmd = cmd_wr && (wr_byte == key_scan_pkg::CMD_CLEAR);
	assign addr_cmd = cmd_wr && (wr_byte[7:4] == key_scan_pkg::CMD_SET_ADDR);
	assign next_digit = disp_mem_r[scan_nxt];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < key_scan_pkg::NUM_DIGITS; i++) begin
				disp_mem_r[i] <= key_scan_pkg::DISP_RESET;
			end
			wr_ptr_r <= 4'h0;
		end else if (ce) begin
			if (clear_cmd) begin
				for (int i = 0; i < key_scan_pkg::NUM_DIGITS; i++) begin
					disp_mem_r[i] <= key_scan_pkg::DISP_RESET;
				end
				wr_ptr_r <= 4'h0;
			end else if (addr_cmd) begin
				wr_ptr_r <= wr_byte[3:0];
			end else if (data_wr) begin
				disp_mem_r[wr_ptr_r] <= wr_byte;
				wr_ptr_r <= 4'(wr_ptr_r + 4'h1);
			end
		end
	end

	// ==========================================
	// scan and digit outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			scan_select_lines <= 4'h0;
			digit_data_low_group <= 4'h0;
			digit_data_high_group <= 4'h0;
			key_scan_n <= 1'b1;
		end else if (ce && digit_step) begin
			scan_select_lines <= scan_nxt;
			digit_data_low_group <= next_digit[3:0];
			digit_data_high_group <= next_digit[7:4];
			key_scan_n <= (scan_nxt != key_scan_pkg::SCAN_PULSE_SLOT);
		end
	end

	// ==========================================
	// key sensing and position code
	logic [7:0] raw_down;
	logic [7:0] seen_down;
	logic any_seen;
	logic prev_down_r;
	logic press_evt;
	logic step_held_r;
	logic [2:0] ret_idx;
	logic [7:0] new_code;
	logic [7:0] key_code_r;

	function automatic logic [2:0] lowest_set(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	assign raw_down = ~ret_s_r;
	// the gate pulse cuts the scan path, so a held key looks released for one scan
	assign seen_down = repeat_pulse_gate ? 8'h00 : raw_down;
	assign any_seen = |seen_down;
	assign press_evt = sample_evt && any_seen && !prev_down_r;
	assign ret_idx = lowest_set(seen_down);
	assign new_code = {1'b0, scan_r, ret_idx};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			prev_down_r <= 1'b0;
			step_held_r <= 1'b0;
			key_code_r <= key_scan_pkg::CODE_RESET;
		end else if (ce && sample_evt) begin
			prev_down_r <= any_seen;
			// gate breaks the return path outside too, so a gated sample keeps the held state
			step_held_r <= repeat_pulse_gate ? step_held_r : |(raw_down & STEP_RETURN_MASK);
			if (press_evt) begin
				key_code_r <= new_code;
			end
		end
	end

	// ==========================================
	// auto-repeat
	logic borrow;

	repeat_counter #(
		.UPPER_SLOW(key_scan_pkg::UPPER_SLOW),
		.UPPER_FAST(key_scan_pkg::UPPER_FAST),
		.TEN_LAST(key_scan_pkg::TEN_LAST)
	) u_repeat (
		.core_clk(core_clk),
		.reset(reset),
		.ce(ce),
		.hold(step_held_r),
		.tick(sample_evt),
		.borrow(borrow)
	);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			repeat_pulse_gate <= 1'b0;
		end else if (ce) begin
			if (!step_held_r) begin
				repeat_pulse_gate <= 1'b0;
			end else if (borrow) begin
				repeat_pulse_gate <= 1'b1;
			end else if (sample_evt) begin
				repeat_pulse_gate <= 1'b0;
			end
		end
	end

	// ==========================================
	// interrupt and read-back
	logic irq_nxt;
	logic [7:0] status;

	// a press in the same cycle as the code read keeps the request up
	assign irq_nxt = press_evt || (key_interrupt && !code_read);
	assign status = (8'(key_interrupt) << key_scan_pkg::STAT_KEY_BIT)
		| (8'(step_held_r) << key_scan_pkg::STAT_REPEAT_BIT);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			key_interrupt <= 1'b0;
			bus_data_out <= 8'h00;
			bus_data_oe <= 1'b0;
		end else if (ce) begin
			key_interrupt <= irq_nxt;
			bus_data_out <= bus_s_r.cd ? status : key_code_r;
			bus_data_oe <= rd_active;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_scan_step: assert property ($changed(scan_select_lines) |->
		scan_select_lines == 4'($past(scan_select_lines) + 4'h1))
		else $error("scan select skipped a position");
	a_digit_sync: assert property ((ce && digit_step && !wr_done) |=>
		digit_data_low_group == disp_mem_r[scan_select_lines][3:0]
		&& digit_data_high_group == disp_mem_r[scan_select_lines][7:4])
		else $error("digit data out of step with scan");
	a_scan_pulse: assert property ($fell(key_scan_n) |-> scan_select_lines == 4'h0)
		else $error("key scan pulse in wrong slot");
	a_code_capture: assert property ((ce && press_evt) |=> key_code_r == $past(new_code))
		else $error("position code not stored on press");
	a_irq_sticky: assert property ((key_interrupt && !code_read && ce) |=> key_interrupt)
		else $error("key request dropped before code read");
	a_irq_press: assert property ($rose(key_interrupt) |-> $past(press_evt))
		else $error("key request without a press");
	a_gate_borrow: assert property ((ce && borrow) |=> repeat_pulse_gate)
		else $error("borrow gave no gate pulse");
	a_gate_release: assert property ((ce && !step_held_r) |=> !repeat_pulse_gate)
		else $error("gate pulse without held step key");
	a_gate_masks: assert property ((ce && sample_evt && repeat_pulse_gate) |=> !prev_down_r)
		else $error("gate pulse did not break the key path");

	sequence s_press_seen;
		ce && press_evt;
	endsequence
	sequence s_code_taken;
		ce && code_read && !press_evt;
	endsequence

	a_irq_raise: assert property (s_press_seen |=> key_interrupt)
		else $error("press raised no key request");
	a_irq_clear: assert property (s_code_taken |=> !key_interrupt)
		else $error("key request kept after code read");
	a_scan_low: assert property ((ce && digit_step) |=> key_scan_n == (scan_select_lines != 4'h0))
		else $error("key scan pulse not tied to position zero");
	a_code_out: assert property ((ce && rd_active && !bus_s_r.cd) |=>
		bus_data_oe && bus_data_out == $past(key_code_r))
		else $error("position code not on the bus during read");
	a_status_out: assert property ((ce && rd_active && bus_s_r.cd) |=>
		bus_data_out[key_scan_pkg::STAT_KEY_BIT] == $past(key_interrupt))
		else $error("status does not show the key request");
	a_gate_one_scan: assert property ((ce && sample_evt && repeat_pulse_gate && !borrow) |=>
		!repeat_pulse_gate)
		else $error("gate pulse lasted past one scan");
	a_held_gated: assert property ((ce && sample_evt && repeat_pulse_gate) |=> $stable(step_held_r))
		else $error("gated sample changed the held step key");
endmodule

/* test/cpu_bus_model.sv */
// processor model: byte writes and reads on the front-panel port pair
// assumes one access at a time, read data is checked by the bench
`timescale 1ns/10ps
module cpu_bus_model (
	input wire logic core_clk,
	input wire logic bus_data_oe,
	output logic bus_rd_n,
	output logic bus_wr_n,
	output logic bus_cs_n,
	output logic bus_cd,
	output logic [7:0] bus_data_in
);
	// ==========================================
	// idle levels
	initial begin
		bus_rd_n = 1'b1;
		bus_wr_n = 1'b1;
		bus_cs_n = 1'b1;
		bus_cd = 1'b0;
		bus_data_in = 8'hA5;
	end
	// ==========================================
	// accesses; strobes held 4 clocks because the pins pass a 2-flop sync
	task automatic sel(input logic [15:0] a);
		bus_cs_n = (a[15:1] != key_scan_pkg::DATA_PORT_ADDR[15:1]);
		bus_cd = a[0];
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sel(a);
		bus_data_in = d;
		bus_wr_n = 1'b0;
		repeat (4) @(negedge core_clk);
		bus_wr_n = 1'b1;
		repeat (4) @(negedge core_clk);
		bus_cs_n = 1'b1;
		// released bus shows no stale byte
		bus_data_in = ~d;
		repeat (2) @(negedge core_clk);
	endtask
	task automatic rd(input logic [15:0] a);
		int i;
		@(negedge core_clk);
		sel(a);
		bus_rd_n = 1'b0;
		for (i = 0; i < 12 && bus_data_oe !== 1'b1; i++) @(negedge core_clk);
		@(negedge core_clk);
		bus_rd_n = 1'b1;
		repeat (4) @(negedge core_clk);
		bus_cs_n = 1'b1;
		repeat (2) @(negedge core_clk);
	endtask
endmodule

/* test/key_scan_autorepeat_test.sv */
// bench for the front-panel scan unit: display, key codes, auto-repeat
// assumes a short digit time, so one scan cycle is 16 * DIG clocks
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module key_scan_autorepeat_test;
	localparam int DIG = 5;
	localparam int P = 16 * DIG;
	localparam logic [15:0] DAT = key_scan_pkg::DATA_PORT_ADDR;
	localparam logic [15:0] CMD = key_scan_pkg::CMD_PORT_ADDR;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [15:0] outs;
	logic bus_rd_n, bus_wr_n, bus_cs_n, bus_cd, bus_data_oe, repeat_pulse_gate, key_interrupt, key_scan_n;
	logic [7:0] bus_data_in, bus_data_out, exp_v;
	logic [7:0] key_return_lines = 8'hFF;
	logic [7:0] keys = 8'h00;
	logic [7:0] shadow [16];
	logic [3:0] scan_select_lines, digit_data_low_group, digit_data_high_group;
	logic [3:0] scan_q = 4'h0;
	logic [7:0] exp_q [$];
	int gates [$];
	int n_mismatch = 0, comparisons = 0, cyc = 0, last_step = 0, gate_up = 0, int_at = 0, i, k;
	int seed = 32'h939D;
	bit disp_on = 0, oe_q = 0;
	always #20 core_clk = ~core_clk;
	// cycle count runs only while enabled, so frozen spans do not skew the timing checks
	always @(posedge core_clk) if (ce) cyc <= cyc + 1;
	key_scan_autorepeat #(.DIGIT_CYCLES(DIG), .STEP_RETURN_MASK(8'hF0)) key_scan_autorepeat_inst (
		.core_clk(core_clk), .reset(reset), .ce(ce), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
		.bus_cs_n(bus_cs_n), .bus_cd(bus_cd), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .key_return_lines(key_return_lines), .scan_select_lines(scan_select_lines),
		.digit_data_low_group(digit_data_low_group), .digit_data_high_group(digit_data_high_group),
		.key_scan_n(key_scan_n), .repeat_pulse_gate(repeat_pulse_gate), .key_interrupt(key_interrupt));
	cpu_bus_model cpu_bus_model_inst (.core_clk(core_clk), .bus_data_oe(bus_data_oe), .bus_rd_n(bus_rd_n),
		.bus_wr_n(bus_wr_n), .bus_cs_n(bus_cs_n), .bus_cd(bus_cd), .bus_data_in(bus_data_in));
	// ==========================================
	// key matrix: a closed key passes the scan pulse unless the gate breaks it
	always @(negedge core_clk) key_return_lines <= ~(keys & {8{!key_scan_n && !repeat_pulse_gate}});
	// ==========================================
	// monitors
	always @(negedge core_clk) begin
		if (!reset) begin
			// first digit after reset leaves the pulse high, so start after the first step
			if (last_step != 0) `CHK(key_scan_n, scan_select_lines != 4'h0)
			if (scan_select_lines !== scan_q) begin
				`CHK(scan_select_lines, scan_q + 4'h1)
				if (last_step != 0) `CHK(cyc - last_step, DIG)
				last_step = cyc;
				if (disp_on) `CHK({digit_data_high_group, digit_data_low_group}, shadow[scan_select_lines])
			end
			scan_q = scan_select_lines;
		end
		if (bus_data_oe === 1'b1 && !oe_q) begin
			exp_v = exp_q.pop_front();
			`CHK(bus_data_out, exp_v)
		end
		oe_q = (bus_data_oe === 1'b1);
		if (repeat_pulse_gate === 1'b1 && gate_up == 0) begin
			gate_up = cyc;
			gates.push_back(cyc);
		end
		if (repeat_pulse_gate === 1'b0 && gate_up != 0) begin
			`CHK(cyc - gate_up, P)
			gate_up = 0;
		end
	end
	// ==========================================
	// tasks
	function automatic logic [7:0] code(input logic [2:0] r);
		return {1'b0, key_scan_pkg::SCAN_PULSE_SLOT, r};
	endfunction
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		cpu_bus_model_inst.rd(a);
	endtask
	task automatic wait_int();
		int j;
		for (j = 0; j < 3 * P && key_interrupt !== 1'b1; j++) @(negedge core_clk);
		int_at = cyc;
		`CHK(key_interrupt, 1'b1)
	endtask
	task automatic press(input logic [7:0] m, input logic [2:0] r, input logic [7:0] stat);
		keys <= m;
		wait_int();
		rd(CMD, stat);
		rd(DAT, code(r));
	endtask
	task automatic wait_gate(input int n);
		int j;
		for (j = 0; j < 100 * P && gates.size() <= n; j++) @(negedge core_clk);
	endtask
	task automatic results();
		`CHK(exp_q.size(), 0)
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (800 * P) @(posedge core_clk);
		n_mismatch++;
		results();
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (12) @(negedge core_clk);
		outs = {scan_select_lines, digit_data_low_group, digit_data_high_group, repeat_pulse_gate, key_interrupt};
		outs = {outs[13:0], bus_data_oe, key_scan_n};
		`CHK(outs, 16'h0001)
		reset = 1'b0;
		// pointer set, clear, an ignored command, then a pointer wrap
		cpu_bus_model_inst.wr(CMD, {key_scan_pkg::CMD_SET_ADDR, 4'h3});
		cpu_bus_model_inst.wr(DAT, 8'h11);
		cpu_bus_model_inst.wr(CMD, key_scan_pkg::CMD_CLEAR);
		for (i = 0; i < 16; i++) shadow[i] = 8'h00;
		cpu_bus_model_inst.wr(CMD, {key_scan_pkg::CMD_SET_ADDR, 4'hE});
		cpu_bus_model_inst.wr(CMD, 8'h40);
		for (i = 0; i < 5; i++) begin
			k = $random(seed);
			shadow[(14 + i) % 16] = k[7:0];
			cpu_bus_model_inst.wr(DAT, k[7:0]);
		end
		disp_on = 1;
		repeat (2 * P) @(negedge core_clk);
		// plain key: one request, no repeat while held
		press(8'h04, 3'h2, 8'h01);
		k = 0;
		for (i = 0; i < 85 * P; i++) begin
			@(negedge core_clk);
			k += (key_interrupt === 1'b1) + (repeat_pulse_gate === 1'b1);
		end
		`CHK(k, 0)
		keys <= 8'h00;
		repeat (2 * P) @(negedge core_clk);
		// clock enable low freezes the scan
		ce <= 1'b0;
		k = scan_select_lines;
		repeat (4 * DIG) @(negedge core_clk);
		`CHK(scan_select_lines, k[3:0])
		ce <= 1'b1;
		// step key: three slow steps, then fast ones
		press(8'h20, 3'h5, 8'h03);
		k = int_at;
		for (i = 0; i < 5; i++) begin
			wait_gate(i);
			if (i == 0) `CHK((gates[0] - k) inside {[79 * P:81 * P]}, 1'b1)
			else `CHK(gates[i] - gates[i - 1], (i < 3 ? 80 : 20) * P)
			wait_int();
			rd(DAT, code(3'h5));
		end
		keys <= 8'h00;
		repeat (2 * P) @(negedge core_clk);
		`CHK(repeat_pulse_gate, 1'b0)
		rd(CMD, 8'h00);
		press(8'h10, 3'h4, 8'h03);
		k = int_at;
		wait_gate(5);
		`CHK((gates[5] - k) inside {[79 * P:81 * P]}, 1'b1)
		keys <= 8'h00;
		repeat (2 * P) @(negedge core_clk);
		results();
	end
endmodule
